// ===== logic/epi_pkg.sv
package epi_pkg;
    localparam int EPI_ADDR_W = 16;
    localparam int EPI_DATA_W = 16;
    localparam int EPI_ID_ARM_BIT = 9;
    localparam int EPI_ID_SEL_BIT = 0;
    localparam int EPI_VAR_W = 3;
    // Variant codes
    localparam logic [2:0] EPI_VAR_HS_A = 3'h0;
    localparam logic [2:0] EPI_VAR_STD_S = 3'h1;
    localparam logic [2:0] EPI_VAR_HS_B = 3'h2;
    localparam logic [2:0] EPI_VAR_STD_32K = 3'h3;
    localparam logic [2:0] EPI_VAR_STD_L = 3'h4;
    localparam logic [2:0] EPI_VAR_WORD = 3'h5;
    // Cycle timing at 10 MHz
    localparam int EPI_CLK_MHZ = 10;
    localparam int EPI_SETUP_NS = 2000;
    localparam int EPI_SETUP_CYC = (EPI_SETUP_NS * EPI_CLK_MHZ + 999) / 1000;
    localparam int EPI_PULSE_US = 100;
    localparam int EPI_PULSE_CYC = EPI_PULSE_US * EPI_CLK_MHZ;
    localparam int EPI_HOLD_NS = 2000;
    localparam int EPI_HOLD_CYC = (EPI_HOLD_NS * EPI_CLK_MHZ + 999) / 1000;
    localparam int EPI_CNT_W = 16;

    typedef struct packed {
        logic supply_hi;
        logic gate_hv;
        logic id_arm_hv;
        logic chip_select_b;
        logic drive_allow_b;
        logic program_pulse_b;
    } epi_ctl_t;

    typedef struct packed {
        logic [EPI_ADDR_W-1:0] addr;
        logic [EPI_DATA_W-1:0] data;
        logic [EPI_VAR_W-1:0] variant;
    } epi_req_t;

    localparam epi_ctl_t EPI_CTL_IDLE = '{
        supply_hi: 1'b0, gate_hv: 1'b0, id_arm_hv: 1'b0,
        chip_select_b: 1'b1, drive_allow_b: 1'b1, program_pulse_b: 1'b1};
endpackage : epi_pkg

// ===== logic/epi_programmer.sv
`timescale 1ns/1ps
module epi_programmer
    import epi_pkg::*;
#(
    parameter int PULSE_CYC = EPI_PULSE_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic prog_start,
    input wire logic id_start,
    input wire epi_req_t req,
    output logic busy,
    output logic done,
    output logic [EPI_DATA_W-1:0] id_maker,
    output logic [EPI_DATA_W-1:0] id_product,
    output epi_ctl_t ctl,
    output logic [EPI_ADDR_W-1:0] addr_out,
    output logic [EPI_DATA_W-1:0] data_out,
    output logic [EPI_DATA_W-1:0] data_oe_b,
    input wire logic [EPI_DATA_W-1:0] data_in
);
    typedef enum {
        EPI_IDLE, EPI_P_SETUP, EPI_P_PULSE, EPI_P_HOLD,
        EPI_I_SETUP0, EPI_I_READ0, EPI_I_SETUP1, EPI_I_READ1
    } epi_state_t;

    epi_state_t state, next_state;
    logic [EPI_CNT_W-1:0] cnt;
    logic [EPI_VAR_W-1:0] var_q;
    logic [EPI_DATA_W-1:0] wdata;
    logic [EPI_ADDR_W-1:0] waddr;

    wire logic cnt_zero = (cnt == '0);
    wire logic is_hs = (var_q == EPI_VAR_HS_A) || (var_q == EPI_VAR_HS_B);
    wire logic is_word = (var_q == EPI_VAR_WORD);
    wire logic uses_pulse = (var_q == EPI_VAR_STD_S) || is_word;
    wire logic prog_phase = (state == EPI_P_SETUP) ||
        (state == EPI_P_PULSE) || (state == EPI_P_HOLD);
    wire logic id_phase = (state == EPI_I_SETUP0) ||
        (state == EPI_I_READ0) || (state == EPI_I_SETUP1) ||
        (state == EPI_I_READ1);
    wire logic id_sel = (state == EPI_I_SETUP1) || (state == EPI_I_READ1);
    // Byte parts drive only the low eight lanes
    wire logic [EPI_DATA_W-1:0] lane_mask =
        is_word ? {EPI_DATA_W{1'b1}} : 16'h00FF;

    // Variant decode; an unknown code raises nothing
    wire logic var_std_s = (var_q == EPI_VAR_STD_S);
    wire logic var_std_32k = (var_q == EPI_VAR_STD_32K);
    wire logic var_std_l = (var_q == EPI_VAR_STD_L);
    wire logic var_known = is_hs || var_std_s || var_std_32k ||
        var_std_l || is_word;
    wire logic want_supply = var_std_s || var_std_32k || is_word;
    wire logic want_gate = is_hs || var_std_l;
    wire logic want_oe_high = var_std_32k || is_word;
    wire logic pulse_now = (state == EPI_P_PULSE) && uses_pulse;

    // Variant pin patterns for programming entry
    epi_ctl_t prog_ctl;
    always_comb begin
        prog_ctl = EPI_CTL_IDLE;
        prog_ctl.supply_hi = want_supply;
        // Combined pin carries supply at its 12.75 V level
        prog_ctl.gate_hv = want_gate;
        prog_ctl.chip_select_b = !var_known;
        prog_ctl.drive_allow_b = want_oe_high;
        // Only the smallest and word parts have a pulse pin
        prog_ctl.program_pulse_b = !pulse_now;
    end

    // Identifier: select, gate and other addresses held low
    epi_ctl_t id_ctl;
    always_comb begin
        id_ctl = EPI_CTL_IDLE;
        id_ctl.id_arm_hv = 1'b1;
        id_ctl.chip_select_b = 1'b0;
        id_ctl.drive_allow_b = 1'b0;
    end

    // Standard parts: ones left unchanged, so all-ones words skip the pulse
    wire logic skip_pulse = !is_hs &&
        ((wdata & lane_mask) == lane_mask);

    wire epi_ctl_t next_ctl = prog_phase ? prog_ctl :
        (id_phase ? id_ctl : EPI_CTL_IDLE);
    wire logic [EPI_ADDR_W-1:0] id_addr =
        EPI_ADDR_W'(id_sel) << EPI_ID_SEL_BIT;
    wire logic [EPI_ADDR_W-1:0] next_addr = prog_phase ? waddr :
        (id_phase ? id_addr : '0);
    wire logic [EPI_DATA_W-1:0] next_oe_b = prog_phase ? ~lane_mask :
        {EPI_DATA_W{1'b1}};

    always_comb begin
        next_state = state;
        case (state)
            EPI_IDLE: begin
                if (prog_start) begin
                    next_state = EPI_P_SETUP;
                end else if (id_start) begin
                    next_state = EPI_I_SETUP0;
                end
            end
            EPI_P_SETUP: begin
                if (cnt_zero) begin
                    next_state = skip_pulse ? EPI_P_HOLD : EPI_P_PULSE;
                end
            end
            EPI_P_PULSE: begin
                if (cnt_zero) begin
                    next_state = EPI_P_HOLD;
                end
            end
            EPI_P_HOLD: begin
                if (cnt_zero) begin
                    next_state = EPI_IDLE;
                end
            end
            EPI_I_SETUP0: begin
                if (cnt_zero) begin
                    next_state = EPI_I_READ0;
                end
            end
            EPI_I_READ0: begin
                next_state = EPI_I_SETUP1;
            end
            EPI_I_SETUP1: begin
                if (cnt_zero) begin
                    next_state = EPI_I_READ1;
                end
            end
            EPI_I_READ1: begin
                next_state = EPI_IDLE;
            end
            default: begin
                next_state = EPI_IDLE;
            end
        endcase
    end

    wire logic state_change = (next_state != state);
    wire logic [EPI_CNT_W-1:0] next_cnt =
        (next_state == EPI_P_PULSE) ? EPI_CNT_W'(PULSE_CYC - 1) :
        (next_state == EPI_P_HOLD) ? EPI_CNT_W'(EPI_HOLD_CYC - 1) :
        EPI_CNT_W'(EPI_SETUP_CYC - 1);
    wire logic finish = state_change && (next_state == EPI_IDLE) &&
        (state != EPI_IDLE);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= EPI_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= '0;
        end else begin
            cnt <= state_change ? next_cnt : (cnt_zero ? cnt : cnt - 1'b1);
        end
    end

    // Request captured once; stable until the operation ends
    wire logic take = (state == EPI_IDLE) && (prog_start || id_start);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            var_q <= '0;
        end else if (take) begin
            var_q <= req.variant;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wdata <= '0;
        end else if (take) begin
            wdata <= req.data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            waddr <= '0;
        end else if (take) begin
            waddr <= req.addr;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl <= EPI_CTL_IDLE;
        end else begin
            ctl <= next_ctl;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_out <= '0;
        end else begin
            addr_out <= next_addr;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
        end else begin
            busy <= (next_state != EPI_IDLE);
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            done <= 1'b0;
        end else begin
            done <= finish;
        end
    end

    // Sampled at the end of each read slot, lanes held since setup
    wire logic take_maker = (state == EPI_I_READ0);
    wire logic take_product = (state == EPI_I_READ1);
    // Lanes fall to zero outside programming so no stale word lingers
    wire logic [EPI_DATA_W-1:0] next_data = prog_phase ?
        (wdata & lane_mask) : '0;

    genvar lane;
    generate
        for (lane = 0; lane < EPI_DATA_W; lane++) begin : g_lane
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    data_out[lane] <= 1'b0;
                end else begin
                    data_out[lane] <= next_data[lane];
                end
            end

            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    data_oe_b[lane] <= 1'b1;
                end else begin
                    data_oe_b[lane] <= next_oe_b[lane];
                end
            end

            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    id_maker[lane] <= 1'b0;
                end else if (take_maker) begin
                    id_maker[lane] <= data_in[lane] & lane_mask[lane];
                end
            end

            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    id_product[lane] <= 1'b0;
                end else if (take_product) begin
                    id_product[lane] <= data_in[lane] & lane_mask[lane];
                end
            end
        end
    endgenerate
endmodule : epi_programmer

// ===== dv/epi_programmer_properties.sv
`timescale 1ns/1ps
module epi_programmer_properties
    import epi_pkg::*;
#(
    parameter int PULSE_CYC = 5
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic prog_start,
    input wire logic id_start,
    input wire epi_req_t req,
    input wire logic busy,
    input wire logic done,
    input wire logic [EPI_DATA_W-1:0] id_maker,
    input wire logic [EPI_DATA_W-1:0] id_product,
    input wire epi_ctl_t ctl,
    input wire logic [EPI_ADDR_W-1:0] addr_out,
    input wire logic [EPI_DATA_W-1:0] data_out,
    input wire logic [EPI_DATA_W-1:0] data_oe_b,
    input wire logic [EPI_DATA_W-1:0] data_in
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_go; prog_start && !busy && !done; endsequence
    sequence s_id; id_start && !prog_start && !busy && !done; endsequence
    sequence s_enter; busy && (ctl.supply_hi || ctl.gate_hv); endsequence
    property p_enter; s_go |=> busy ##1 s_enter ##1 busy [*7]; endproperty
    property p_idgo; s_id |=> busy ##1 (busy && ctl.id_arm_hv); endproperty
    property p_idpins;
        ctl.id_arm_hv |-> !ctl.chip_select_b && !ctl.drive_allow_b
            && (addr_out & 16'hFDFE) == 16'h0000;
    endproperty
    property p_idsafe;
        ctl.id_arm_hv |-> !ctl.supply_hi && !ctl.gate_hv && &data_oe_b;
    endproperty
    property p_pulse;
        !ctl.program_pulse_b |-> ctl.supply_hi && !ctl.chip_select_b;
    endproperty
    property p_sel;
        ctl.supply_hi |-> !ctl.chip_select_b && !ctl.id_arm_hv;
    endproperty
    property p_stable;
        busy && $past(busy) && $past(busy, 2) && !ctl.id_arm_hv
            && !$past(ctl.id_arm_hv)
            |-> $stable(addr_out) && $stable(data_out);
    endproperty
    property p_upper; &data_oe_b[15:8] |-> data_out[15:8] == 8'h00; endproperty
    property p_done; $fell(busy) |-> done ##1 !done; endproperty
    a_enter: assert property (p_enter) else $error("no entry");
    a_idgo: assert property (p_idgo) else $error("no id arm");
    a_idpins: assert property (p_idpins) else $error("id pins");
    a_idsafe: assert property (p_idsafe) else $error("id unsafe");
    a_pulse: assert property (p_pulse) else $error("stray pulse");
    a_sel: assert property (p_sel) else $error("supply w/o select");
    a_stable: assert property (p_stable) else $error("unstable");
    a_upper: assert property (p_upper) else $error("upper lanes");
    a_done: assert property (p_done) else $error("done pulse");
endmodule : epi_programmer_properties

bind epi_programmer epi_programmer_properties #(.PULSE_CYC(PULSE_CYC))
    u_props (.*);

// ===== dv/epi_dev_model.sv
`timescale 1ns/1ps
module epi_dev_model
    import epi_pkg::*;
#(
    parameter logic [15:0] MAKER = 16'h00C3,
    parameter logic [15:0] PRODUCT = 16'h003C
) (
    input wire logic core_clk,
    input wire epi_ctl_t ctl,
    input wire logic [EPI_ADDR_W-1:0] addr_out,
    input wire logic [EPI_DATA_W-1:0] data_out,
    output logic [EPI_DATA_W-1:0] data_in
);
    logic tog = 1'b0;
    logic [EPI_DATA_W-1:0] word = 16'hFFFF;
    wire id_mode = ctl.id_arm_hv && !ctl.chip_select_b;
    wire sel = !ctl.chip_select_b;
    wire program_pulse_pin = ctl.gate_hv || (ctl.supply_hi && sel);
    always @(posedge core_clk) begin
        tog <= !tog;
        if (program_pulse_pin) begin
            word <= data_out;
        end
    end
    // Released lines wander so a stale value never passes
    assign data_in = id_mode ? (addr_out[0] ? PRODUCT : MAKER)
        : {16{tog}};
endmodule : epi_dev_model

// ===== dv/tb_epi_programmer.sv
`timescale 1ns/1ps
module tb_epi_programmer
    import epi_pkg::*;
;
    localparam int PC = 5;
    localparam logic [15:0] MK = 16'h00A5; // Arbitrary code
    localparam logic [15:0] PR = 16'h005A; // Arbitrary code
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic prog_start = 1'b0;
    logic id_start = 1'b0;
    epi_req_t req = '0;
    logic busy, done;
    logic [15:0] id_maker, id_product, addr_out, data_out, data_oe_b, data_in;
    epi_ctl_t ctl;
    int fails = 0;
    int n_checks = 0;
    int n;
    logic seen;
    wire sp = ctl.supply_hi;
    wire cs = !ctl.chip_select_b;
    wire pl = !ctl.program_pulse_b;
    wire dh = ctl.drive_allow_b;
    wire gh = ctl.gate_hv;

    epi_programmer #(.PULSE_CYC(PC)) u_dut (.*);
    epi_dev_model #(.MAKER(MK), .PRODUCT(PR)) u_dev (.*);

    initial begin
        forever #50 core_clk = !core_clk;
    end

    task automatic chk(input logic [15:0] got, exp, input string m);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    function automatic logic mode(input logic [2:0] v);
        case (v)
            EPI_VAR_STD_S: return sp && cs && pl;
            EPI_VAR_STD_32K: return sp && cs && dh;
            EPI_VAR_STD_L: return gh && cs;
            EPI_VAR_WORD: return sp && cs && pl && dh;
            default: return gh;
        endcase
    endfunction : mode

    // A poke holds id_start into the busy phase, where it must be ignored
    task automatic go(input logic p, input logic [2:0] v,
            input logic [15:0] d, input logic poke);
        @(posedge core_clk);
        req <= '{addr: 16'h0123, data: d, variant: v};
        prog_start <= p;
        id_start <= !p;
        @(posedge core_clk);
        prog_start <= 1'b0;
        id_start <= poke;
        n = 0;
        seen = 1'b0;
        while (!done && n < 3000) begin
            @(negedge core_clk);
            n++;
            seen |= mode(v);
            if (poke && n == 10) begin
                @(posedge core_clk);
                id_start <= 1'b0;
            end
        end
        if (n >= 3000) begin
            fails++;
            close_out();
        end
    endtask : go

    task automatic t_variants();
        logic [15:0] d;
        for (int v = 0; v < 6; v++) begin
            d = 16'hA53C ^ 16'(v);
            go(1'b1, 3'(v), d, 1'b0);
            chk({15'h0, seen}, 16'h1, "entry");
            chk(16'(n), 16'(41 + PC), "length");
            chk(u_dev.word, v == 5 ? d : {8'h00, d[7:0]}, "word");
        end
        $display("variants done");
    endtask : t_variants

    task automatic t_ones();
        go(1'b1, EPI_VAR_STD_32K, 16'hFFFF, 1'b0);
        chk(16'(n), 16'd41, "erased skip");
        go(1'b1, EPI_VAR_HS_B, 16'hFFFF, 1'b0);
        chk(16'(n), 16'(41 + PC), "undefined pulse");
        $display("ones done");
    endtask : t_ones

    task automatic t_id();
        go(1'b0, EPI_VAR_STD_32K, 16'h0000, 1'b0);
        chk(16'(n), 16'd43, "id length");
        chk(id_maker, MK, "maker");
        chk(id_product, PR, "product");
        $display("id done");
    endtask : t_id

    task automatic t_refuse();
        go(1'b1, EPI_VAR_WORD, 16'h1234, 1'b1);
        chk(16'(n), 16'(41 + PC), "length");
        repeat (3) begin
            @(negedge core_clk);
            chk({15'h0, busy}, 16'h0, "refused start");
        end
        $display("refuse done");
    endtask : t_refuse

    initial begin
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        t_variants();
        t_ones();
        t_id();
        t_refuse();
        close_out();
    end
endmodule : tb_epi_programmer
